// ==== hdl/spi_master_slave_port.sv ====
/*
 Serial peripheral port, master or slave, 1 to 16 bit frames, two select lines,
 registers on AHB-Lite with zero wait states.
 Assumes pins arrive asynchronously to hclk and are synchronised here; pad drivers
 resolve the wire from the output enables.
*/
`timescale 1ns/10ps
`include "spi_port_map.svh"

// Notes on behaviour
// (RULE_01) Frames of 1 to 16 bits
// (RULE_02) Master sends without reading received data
// (RULE_03) Control may be written with data
// (RULE_04) Two select lines, per-line polarity
// (RULE_05) Master drives clock, toggles only mid-transfer
// (RULE_06) Clock rest level selectable by software
// (RULE_07) Clock driven whenever master bit set
// (RULE_08) MOSI out as master, in as slave
// (RULE_09) MOSI driven whenever master bit set
// (RULE_10) MISO out as slave, in as master
// (RULE_11) MISO driven: enabled, slave, selected
// (RULE_12) Master selects before data, releases after
// (RULE_13) Selects active low by default
// (RULE_14) Slave addressed by any active select
// (RULE_15) Selects driven whenever master bit set
// (RULE_16) Enabled events raise wake while clocked; code leaves master idle (enable bit 8) out of wake
// (RULE_17) Slave raises enabled wake from pin events
// (RULE_18) Wake on select change, receive, overrun
// (RULE_19) Status flags cleared by writing one
// (RULE_20) Enable set by one; reads whole value
// (RULE_21) Disable resets engine and counters
// (RULE_22) Pin directions follow master bit
// (RULE_23) Count bits to length; MSB first default
// (RULE_24) Slave pins synchronised before status update
module spi_master_slave_port
   import spi_port_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Serial pins
   input wire spi_in_s pins_in,
   output spi_out_s pins_out,
   // Wake request to the power controller
   output logic wake_req
);

   st_s s;
   st_s next_s;
   logic [1:0] sel_act;
   logic rst_ready;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Bit currently presented on the data line
   function automatic logic out_bit(input logic [15:0] sh, input logic [3:0] fm1, input logic lsbf);
      out_bit = lsbf ? sh[0] : sh[fm1];
   endfunction

   // Insert one received bit; LSB-first fills from the top of the frame down
   function automatic logic [15:0] rx_ins(input logic [15:0] sh, input logic [3:0] fm1, input logic lsbf,
                                          input logic b);
      logic [15:0] r;
      r = sh;
      if (lsbf) begin
         r = sh >> 1;
         r[fm1] = b;
      end else begin
         r = {sh[14:0], b};
      end
      rx_ins = r;
   endfunction

   // Next transmit bit
   function automatic logic [15:0] tx_adv(input logic [15:0] sh, input logic lsbf);
      tx_adv = lsbf ? (sh >> 1) : (sh << 1);
   endfunction

   // ----------------------------------------------------------------
   // Select line decode
   // ----------------------------------------------------------------

   // Only the second synchroniser stage is looked at
   generate
      for (genvar i = 0; i < 2; i++) begin : g_sel
         assign sel_act[i] = (s.sy2.ssel[i] == s.cfg.spol[i]); // RULE_13 RULE_14
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic lead, trail, tick, in_bit, sel_now, ev_rx, ev_ovr, ev_udr, ev_ssa, ev_ssd, ev_eot, frame_end;
      logic [31:0] st_vec;
      {lead, trail, tick, in_bit, sel_now, ev_rx, ev_ovr, ev_udr, ev_ssa, ev_ssd, ev_eot, frame_end} = 12'h000;
      st_vec = `RST_ZERO32;
      next_s = s;

      // Two-stage synchronisers; third sample serves edge detection
      next_s.sy1 = pins_in; // RULE_24
      next_s.sy2 = s.sy1;
      next_s.sck_q = s.sy2.sck;
      sel_now = |sel_act;
      next_s.sel_q = sel_now;

      // Serial clock edges: divider ticks as master, synchronised pin as slave
      if (s.cfg.master) begin
         tick = (s.divcnt == s.div);
         next_s.divcnt = tick ? `RST_ZERO16 : s.divcnt + 16'h0001;
         lead = tick && (s.eng == eng_shift) && !s.half;
         trail = tick && (s.eng == eng_shift) && s.half;
         in_bit = s.cfg.loop ? out_bit(s.tsh, s.cur.flen_m1, s.cfg.lsbf) : s.sy2.miso; // RULE_10
      end else begin
         lead = sel_now && (s.sy2.sck != s.cfg.cpol) && (s.sck_q == s.cfg.cpol);
         trail = sel_now && (s.sy2.sck == s.cfg.cpol) && (s.sck_q != s.cfg.cpol);
         in_bit = s.sy2.mosi; // RULE_08
      end

      // Bit engine common to both modes
      if (lead) begin
         if (!s.cfg.cpha) begin
            next_s.rsh = rx_ins(s.rsh, s.cur.flen_m1, s.cfg.lsbf, in_bit);
         end else if (s.bitcnt != 4'h0) begin
            next_s.tsh = tx_adv(s.tsh, s.cfg.lsbf);
         end
      end
      if (trail) begin
         if (s.cfg.cpha) begin
            next_s.rsh = rx_ins(s.rsh, s.cur.flen_m1, s.cfg.lsbf, in_bit);
         end else begin
            next_s.tsh = tx_adv(s.tsh, s.cfg.lsbf);
         end
         next_s.bitcnt = s.bitcnt + 4'h1;
         frame_end = (s.bitcnt == s.cur.flen_m1); // RULE_23 RULE_01
      end

      // Frame completion: deliver received word unless told to ignore it
      if (frame_end) begin
         next_s.bitcnt = 4'h0;
         ev_eot = s.cur.eot;
         if (!s.cur.rxignore) begin // RULE_02
            ev_rx = 1'b1;
            ev_ovr = s.rx_ready; // RULE_18
            next_s.rxdata = s.cfg.cpha ? rx_ins(s.rsh, s.cur.flen_m1, s.cfg.lsbf, in_bit)
                                       : next_s.rsh;
            next_s.rx_sel = sel_now ? sel_act : s.sel_on;
            next_s.rx_sot = s.sot;
         end
         next_s.sot = 1'b0;
      end

      // Master sequencer
      if (s.cfg.master) begin
         case (s.eng)
            eng_idle: begin
               next_s.sck_m = s.cfg.cpol; // RULE_06
               if (s.cfg.enable && s.tx_valid) begin
                  next_s.cur = s.txd_ctl; // RULE_03
                  next_s.tsh = s.txdata;
                  next_s.tx_valid = 1'b0;
                  next_s.sel_on = ~s.txd_ctl.desel; // RULE_12
                  next_s.sot = 1'b1;
                  next_s.divcnt = `RST_ZERO16;
                  next_s.eng = eng_setup;
               end
            end
            eng_setup: begin
               // One half period here and one more in shift: a full period of select setup before the first edge
               if (tick) begin
                  next_s.eng = eng_shift;
                  next_s.half = 1'b0;
               end
            end
            eng_shift: begin
               if (tick) begin
                  next_s.half = !s.half;
                  next_s.sck_m = !s.sck_m; // RULE_05
               end
               if (frame_end) begin
                  if (s.cur.eot) begin
                     next_s.eng = eng_hold;
                  end else begin
                     next_s.eng = eng_wait;
                  end
               end
            end
            eng_wait: begin
               // Selects stay asserted while the next word is awaited
               if (s.tx_valid) begin
                  next_s.cur = s.txd_ctl;
                  next_s.tsh = s.txdata;
                  next_s.tx_valid = 1'b0;
                  next_s.sel_on = ~s.txd_ctl.desel;
                  next_s.divcnt = `RST_ZERO16;
                  next_s.eng = eng_setup;
               end
            end
            eng_hold: begin
               if (tick) begin
                  next_s.sel_on = 2'b00; // RULE_12
                  next_s.eng = eng_idle;
               end
            end
            default: begin
               next_s.eng = eng_idle;
            end
         endcase
      end else begin
         // Slave: select edges start and end transfers
         next_s.sel_on = 2'b00;
         next_s.eng = eng_idle;
         if (s.cfg.enable && sel_now && !s.sel_q) begin
            ev_ssa = 1'b1; // RULE_18
            next_s.sot = 1'b1;
            next_s.bitcnt = 4'h0;
         end
         if (s.cfg.enable && !sel_now && s.sel_q) begin
            ev_ssd = 1'b1;
            next_s.bitcnt = 4'h0;
         end
         // Load a word at select or at frame end, so the first bit leads the first edge
         if (s.cfg.enable && ((sel_now && !s.sel_q) || frame_end)) begin
            if (s.tx_valid) begin
               next_s.cur = s.txd_ctl;
               next_s.tsh = s.txdata;
               next_s.tx_valid = 1'b0;
            end else begin
               next_s.tsh = `RST_ZERO16;
               ev_udr = 1'b1;
            end
         end
      end

      // Disabled: engine and counters held in reset
      if (!s.cfg.enable) begin
         next_s.eng = eng_idle; // RULE_21
         next_s.bitcnt = 4'h0;
         next_s.divcnt = `RST_ZERO16;
         next_s.half = 1'b0;
         next_s.sel_on = 2'b00;
         next_s.sck_m = s.cfg.cpol;
         next_s.sot = 1'b0;
      end

      // Bus write, data phase
      if (s.ph_act && s.ph_wr) begin
         case (s.ph_addr)
            `OFF_CONFIGURATION: begin
               next_s.cfg.enable = hwdata[`CFG_ENABLE];
               next_s.cfg.master = hwdata[`CFG_MASTER];
               next_s.cfg.lsbf = hwdata[`CFG_LSBF];
               next_s.cfg.cpha = hwdata[`CFG_CPHA];
               next_s.cfg.cpol = hwdata[`CFG_CPOL];
               next_s.cfg.loop = hwdata[`CFG_LOOP];
               next_s.cfg.spol = hwdata[`CFG_SPOL1:`CFG_SPOL0]; // RULE_04
            end
            `OFF_TIMING_DELAYS: begin
               next_s.dly = hwdata;
            end
            `OFF_FLAGS_STATUS: begin
               if (hwdata[`ST_RXOV]) next_s.ovr = 1'b0; // RULE_19
               if (hwdata[`ST_TXUR]) next_s.udr = 1'b0;
               if (hwdata[`ST_SSA]) next_s.ssa = 1'b0;
               if (hwdata[`ST_SSD]) next_s.ssd = 1'b0;
               if (hwdata[`ST_EOT]) next_s.eotf = 1'b0;
            end
            `OFF_IRQ_ENABLE_SET: begin
               next_s.inten = s.inten | (hwdata[8:0] & `IEN_MASK); // RULE_20
            end
            `OFF_IRQ_ENABLE_CLR: begin
               next_s.inten = s.inten & ~hwdata[8:0];
            end
            `OFF_TX_DATA_CTL: begin
               next_s.txdata = hwdata[`TXC_DATA_HI:0];
               next_s.txctl = {hwdata[`TXC_FLEN_HI:`TXC_FLEN_LO], hwdata[`TXC_RXIGNORE], hwdata[`TXC_EOT],
                               hwdata[`TXC_DESEL_HI:`TXC_DESEL_LO]};
               next_s.txd_ctl = next_s.txctl; // RULE_03
               next_s.tx_valid = 1'b1;
            end
            `OFF_TX_DATA: begin
               next_s.txdata = hwdata[`TXC_DATA_HI:0];
               next_s.txd_ctl = s.txctl;
               next_s.tx_valid = 1'b1;
            end
            `OFF_TX_CTL: begin
               next_s.txctl = {hwdata[`TXC_FLEN_HI:`TXC_FLEN_LO], hwdata[`TXC_RXIGNORE], hwdata[`TXC_EOT],
                               hwdata[`TXC_DESEL_HI:`TXC_DESEL_LO]};
            end
            `OFF_CLK_DIV: begin
               next_s.div = hwdata[15:0];
            end
            default: begin
            end
         endcase
      end

      // Address phase: take the request, read data reflects any write just landed
      next_s.ph_act = hsel && htrans[1] && hready;
      next_s.ph_wr = hwrite;
      next_s.ph_addr = {haddr[11:2], 2'b00};
      st_vec[`ST_RXRDY] = next_s.rx_ready;
      st_vec[`ST_TXRDY] = !next_s.tx_valid;
      st_vec[`ST_RXOV] = next_s.ovr;
      st_vec[`ST_TXUR] = next_s.udr;
      st_vec[`ST_SSA] = next_s.ssa;
      st_vec[`ST_SSD] = next_s.ssd;
      st_vec[`ST_EOT] = next_s.eotf;
      st_vec[`ST_MSTIDLE] = (next_s.eng == eng_idle) && !next_s.tx_valid;
      next_s.hrdata = `RST_ZERO32;
      if (next_s.ph_act && !hwrite) begin
         case (next_s.ph_addr)
            `OFF_CONFIGURATION: begin
               next_s.hrdata[`CFG_ENABLE] = next_s.cfg.enable;
               next_s.hrdata[`CFG_MASTER] = next_s.cfg.master;
               next_s.hrdata[`CFG_LSBF] = next_s.cfg.lsbf;
               next_s.hrdata[`CFG_CPHA] = next_s.cfg.cpha;
               next_s.hrdata[`CFG_CPOL] = next_s.cfg.cpol;
               next_s.hrdata[`CFG_LOOP] = next_s.cfg.loop;
               next_s.hrdata[`CFG_SPOL1:`CFG_SPOL0] = next_s.cfg.spol;
            end
            `OFF_TIMING_DELAYS: next_s.hrdata = next_s.dly;
            `OFF_FLAGS_STATUS: next_s.hrdata = st_vec;
            `OFF_IRQ_ENABLE_SET: next_s.hrdata = {23'h000000, next_s.inten}; // RULE_20
            `OFF_RX_DATA: begin
               next_s.hrdata = {11'h000, next_s.rx_sot, 2'b00, next_s.rx_sel, next_s.rxdata};
               next_s.rx_ready = 1'b0;
            end
            `OFF_TX_DATA_CTL, `OFF_TX_CTL: begin
               next_s.hrdata[`TXC_FLEN_HI:`TXC_FLEN_LO] = next_s.txctl.flen_m1;
               next_s.hrdata[`TXC_RXIGNORE] = next_s.txctl.rxignore;
               next_s.hrdata[`TXC_EOT] = next_s.txctl.eot;
               next_s.hrdata[`TXC_DESEL_HI:`TXC_DESEL_LO] = next_s.txctl.desel;
               if (next_s.ph_addr == `OFF_TX_DATA_CTL) next_s.hrdata[`TXC_DATA_HI:0] = next_s.txdata;
            end
            `OFF_TX_DATA: next_s.hrdata = {16'h0000, next_s.txdata};
            `OFF_CLK_DIV: next_s.hrdata = {16'h0000, next_s.div};
            default: next_s.hrdata = `RST_ZERO32;
         endcase
      end

      // Hardware events win over software clears in the same cycle
      if (ev_rx) next_s.rx_ready = 1'b1;
      if (ev_ovr) next_s.ovr = 1'b1;
      if (ev_udr) next_s.udr = 1'b1;
      if (ev_ssa) next_s.ssa = 1'b1;
      if (ev_ssd) next_s.ssd = 1'b1;
      if (ev_eot) next_s.eotf = 1'b1;

      // Wake: any enabled event except master idle (enable bit 8); slave events come from pin activity alone
      next_s.wake = |({next_s.eotf, 1'b0, next_s.ssd, next_s.ssa, next_s.udr, next_s.ovr, !next_s.tx_valid,
                       next_s.rx_ready} & next_s.inten[7:0]); // RULE_16 RULE_17 RULE_18

      // Pin drivers, directions set by the master bit
      next_s.pins.sck_oe = next_s.cfg.master; // RULE_07 RULE_22
      next_s.pins.sck_o = next_s.sck_m;
      next_s.pins.mosi_oe = next_s.cfg.master; // RULE_09
      next_s.pins.mosi_o = out_bit(next_s.tsh, next_s.cur.flen_m1, next_s.cfg.lsbf); // RULE_08
      next_s.pins.ssel_oe = {2{next_s.cfg.master}}; // RULE_15
      next_s.pins.ssel_o = ~(next_s.sel_on ^ next_s.cfg.spol); // RULE_13
      next_s.pins.miso_oe = next_s.cfg.enable && !next_s.cfg.master && sel_now; // RULE_11
      next_s.pins.miso_o = out_bit(next_s.tsh, next_s.cur.flen_m1, next_s.cfg.lsbf); // RULE_10
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Reset leaves selects released high (active low default) and the bus not ready until the first clock after it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.eng <= eng_idle;
         s.pins.ssel_o <= 2'b11;
         rst_ready <= 1'b0;
      end else begin
         s <= next_s;
         rst_ready <= 1'b1;
      end
   end

   assign hreadyout = rst_ready;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign pins_out = s.pins;
   assign wake_req = s.wake;

endmodule

// ==== hdl/spi_port_map.svh ====
/*
 Register map, field positions and reset values of the serial port.
 Assumes a 32-bit AHB-Lite slave, word-aligned registers, one clock at 40 MHz.
*/
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CONFIGURATION 12'h000
`define OFF_TIMING_DELAYS 12'h004
`define OFF_FLAGS_STATUS 12'h008
`define OFF_IRQ_ENABLE_SET 12'h00c
`define OFF_IRQ_ENABLE_CLR 12'h010
`define OFF_RX_DATA 12'h014
`define OFF_TX_DATA_CTL 12'h018
`define OFF_TX_DATA 12'h01c
`define OFF_TX_CTL 12'h020
`define OFF_CLK_DIV 12'h024

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_ENABLE 0
`define CFG_MASTER 2
`define CFG_LSBF 3
`define CFG_CPHA 4
`define CFG_CPOL 5
`define CFG_LOOP 7
`define CFG_SPOL0 8
`define CFG_SPOL1 9

// ----------------------------------------------------------------
// Transmit control fields (shared by the data+control and control registers)
// ----------------------------------------------------------------
`define TXC_DATA_HI 15
`define TXC_DESEL_LO 16
`define TXC_DESEL_HI 17
`define TXC_EOT 20
`define TXC_RXIGNORE 22
`define TXC_FLEN_LO 24
`define TXC_FLEN_HI 27

// ----------------------------------------------------------------
// Receive data fields
// ----------------------------------------------------------------
`define RXD_SEL_LO 16
`define RXD_SEL_HI 17
`define RXD_SOT 20

// ----------------------------------------------------------------
// Status and interrupt enable bit positions
// ----------------------------------------------------------------
`define ST_RXRDY 0
`define ST_TXRDY 1
`define ST_RXOV 2
`define ST_TXUR 3
`define ST_SSA 4
`define ST_SSD 5
`define ST_EOT 7
`define ST_MSTIDLE 8
`define ST_RESET 32'h0000_0102
`define IEN_MASK 9'h1bf

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ZERO16 16'h0000
`define RST_ZERO32 32'h0000_0000

`endif

// ==== hdl/spi_port_pkg.sv ====
/*
 Types of the serial port: engine states, configuration and control fields, pin carriers.
 Assumes the map header supplies all numbers.
*/
package spi_port_pkg;

   typedef enum logic [2:0] {eng_idle, eng_setup, eng_shift, eng_wait, eng_hold} eng_e;

   typedef struct packed {
      logic [1:0] spol;
      logic loop;
      logic cpol;
      logic cpha;
      logic lsbf;
      logic master;
      logic enable;
   } cfg_s;

   typedef struct packed {
      logic [3:0] flen_m1;
      logic rxignore;
      logic eot;
      logic [1:0] desel;
   } txctl_s;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic [1:0] ssel;
   } spi_in_s;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
      logic [1:0] ssel_o;
      logic [1:0] ssel_oe;
   } spi_out_s;

   typedef struct packed {
      cfg_s cfg;
      logic [31:0] dly;
      logic [15:0] div;
      txctl_s txctl;
      logic [15:0] txdata;
      txctl_s txd_ctl;
      logic tx_valid;
      logic [15:0] rxdata;
      logic [1:0] rx_sel;
      logic rx_sot;
      logic rx_ready;
      logic ovr;
      logic udr;
      logic ssa;
      logic ssd;
      logic eotf;
      logic [8:0] inten;
      eng_e eng;
      logic [15:0] divcnt;
      logic half;
      logic [3:0] bitcnt;
      logic [15:0] tsh;
      logic [15:0] rsh;
      txctl_s cur;
      logic sot;
      logic sck_m;
      logic [1:0] sel_on;
      spi_in_s sy1;
      spi_in_s sy2;
      logic sck_q;
      logic sel_q;
      logic ph_act;
      logic ph_wr;
      logic [11:0] ph_addr;
      logic [31:0] hrdata;
      logic wake;
      spi_out_s pins;
   } st_s;

endpackage

// ==== verification/spi_port_monitor.sv ====
/* Checker of the serial port, bound to its top module.
 Assumes hready is tied to hreadyout and the default select polarity. */
`timescale 1ns/10ps
module spi_port_monitor
   import spi_port_pkg::*;
(
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Pins and wake
   input wire spi_in_s pins_in,
   input wire spi_out_s pins_out,
   input wire logic wake_req
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic ph;
   logic ph_wr;
   logic [11:0] ph_a;
   logic [31:0] cfg;
   logic [8:0] ien;
   // Shadow copies of configuration and enables, taken in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 1'b0;
         ph_wr <= 1'b0;
         ph_a <= 12'h000;
         cfg <= 32'h0;
         ien <= 9'h000;
      end else begin
         ph <= hsel & htrans[1] & hready;
         ph_wr <= hwrite;
         ph_a <= haddr[11:0];
         if (ph && ph_wr && ph_a == 12'h000) cfg <= hwdata;
         if (ph && ph_wr && ph_a == 12'h00c) ien <= ien | (hwdata[8:0] & 9'h1bf);
         if (ph && ph_wr && ph_a == 12'h010) ien <= ien & ~hwdata[8:0];
      end
   end
   sequence s_rest;
      !pins_out.sck_o [*2];
   endsequence
   property p_mst_dirs;
      cfg[2] && $past(cfg[2], 2) |-> pins_out.sck_oe && pins_out.mosi_oe && pins_out.ssel_oe == 2'b11;
   endproperty
   a_mst_dirs: assert property (p_mst_dirs) else $error("master pins not driven");
   property p_slv_dirs;
      !cfg[2] && !$past(cfg[2], 2) |-> !pins_out.sck_oe && !pins_out.mosi_oe && pins_out.ssel_oe == 2'b00;
   endproperty
   a_slv_dirs: assert property (p_slv_dirs) else $error("slave pins driven");
   property p_miso_oe;
      pins_out.miso_oe |-> ($past(cfg[0]) || cfg[0]) && !($past(cfg[2]) && cfg[2]);
   endproperty
   a_miso_oe: assert property (p_miso_oe) else $error("miso driven out of slave mode");
   property p_sel_first;
      $fell(pins_out.ssel_o[0]) |-> s_rest;
   endproperty
   a_sel_first: assert property (p_sel_first) else $error("clock moved with select");
   property p_sel_last;
      $rose(pins_out.ssel_o[0]) && pins_out.ssel_oe[0] |-> !$past(pins_out.sck_o) && !$past(pins_out.sck_o, 2);
   endproperty
   a_sel_last: assert property (p_sel_last) else $error("select released early");
   property p_sck_frame;
      pins_out.sck_oe && $changed(pins_out.sck_o) |-> pins_out.ssel_o != 2'b11;
   endproperty
   a_sck_frame: assert property (p_sck_frame) else $error("clock toggled outside frame");
   property p_wake;
      wake_req |-> (ien | $past(ien) | $past(ien, 2)) != 9'h000;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without enable");
   property p_ien_rd;
      ph && !ph_wr && ph_a == 12'h00c |-> hrdata == {23'h0, ien};
   endproperty
   a_ien_rd: assert property (p_ien_rd) else $error("enable read wrong");
   property p_sync;
      $rose(pins_out.miso_oe) |-> $past(pins_in.ssel, 2) != 2'b11;
   endproperty
   a_sync: assert property (p_sync) else $error("miso ahead of synchroniser");
endmodule
bind spi_master_slave_port spi_port_monitor u_spi_port_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .pins_in, .pins_out, .wake_req);

// ==== verification/spi_slave_model.sv ====
/* Far-side serial slave, clock mode 0, answers 8'h3c MSB first.
 Assumes its select is low only while the port is master. */
`timescale 1ns/10ps
module spi_slave_model (
   // Serial lines
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   output logic miso,
   output logic [7:0] got
);
   logic [7:0] sh = 8'h00;
   // Released line shows the inverse, so stale data never passes
   assign miso = sel_n ? ~sh[7] : sh[7];
   always @(negedge sel_n) sh <= 8'h3c;
   always @(negedge sck) if (!sel_n) sh <= {sh[6:0], 1'b0};
   always @(posedge sck) if (!sel_n) got <= {got[6:0], mosi};
endmodule

// ==== verification/testbench.sv ====
/* Self-checking bench of the serial port.
 Assumes zero-wait AHB-Lite and a mode-0 slave on select line 0. */
`timescale 1ns/10ps
module testbench import spi_port_pkg::*;;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tb_sck = 0, tb_mosi = 0;
   logic [1:0] htrans = 0, tb_ssel = 2'b11;
   logic [31:0] haddr = 0, hwdata = 0, q;
   wire hreadyout, hresp, wake_req, miso_w;
   wire [31:0] hrdata;
   wire [7:0] got;
   spi_in_s pin_w;
   spi_out_s po;
   int error_cnt = 0, total_checks = 0;
   always #12.5 hclk = ~hclk;
   // Wire levels from every driver's enable
   assign pin_w = {po.sck_oe ? po.sck_o : tb_sck, po.mosi_oe ? po.mosi_o : tb_mosi,
      po.miso_oe ? po.miso_o : miso_w, (po.ssel_oe & po.ssel_o) | (~po.ssel_oe & tb_ssel)};
   spi_master_slave_port u_spi_master_slave_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins_in(pin_w), .pins_out(po), .wake_req(wake_req));
   spi_slave_model u_spi_slave_model (.sck(pin_w.sck), .mosi(pin_w.mosi),
      .sel_n(~(po.ssel_oe[0] & ~po.ssel_o[0])), .miso(miso_w), .got(got));
   task stop_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   // Bounded wait for hready at the next edges
   task ph;
      int n;
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin error_cnt++; stop_test; end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'b10; hwrite <= w;
      ph;
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      ph;
      q = hrdata;
   endtask
   task t_regs;
      chk("ssel idle", 2'b11, po.ssel_o);
      bus(0, 12'h000, 0); chk("configuration", 0, q);
      bus(0, 12'h004, 0); chk("timing_delays", 0, q);
      bus(0, 12'h008, 0); chk("flags_status", 32'h102, q);
      bus(0, 12'h030, 0); chk("unmapped", 0, q);
      bus(1, 12'h00c, 1); bus(1, 12'h00c, 4); bus(0, 12'h00c, 0); chk("irq_enable_set", 5, q);
      bus(1, 12'h010, 5); bus(0, 12'h00c, 0); chk("irq_enable_set", 0, q);
      $display("t_regs done");
   endtask
   task t_master;
      int n, k;
      logic seen, last;
      bus(1, 12'h000, 4); repeat (3) @(posedge hclk);
      chk("oe disabled master", 5'b11011, {po.sck_oe, po.mosi_oe, po.miso_oe, po.ssel_oe});
      bus(1, 12'h024, 3); bus(1, 12'h000, 5); bus(1, 12'h00c, 1);
      bus(1, 12'h018, 32'h0712_00a5);
      k = 0; seen = 0; last = 0;
      for (n = 0; n < 300; n++) begin
         @(posedge hclk); #1;
         if (po.sck_o && !last) k++;
         last = po.sck_o;
         if (!po.ssel_o[0]) seen = 1;
         if (seen && po.ssel_o[0]) break;
      end
      chk("frame ended", 1, seen && po.ssel_o[0]);
      @(posedge hclk);
      chk("sck edges", 8, k);
      chk("mosi byte", 8'ha5, got);
      chk("wake", 1, wake_req);
      bus(0, 12'h014, 0); chk("rx byte", 8'h3c, q[7:0]);
      bus(0, 12'h008, 0); chk("eot flag", 1, q[7]);
      bus(1, 12'h008, 32'h80); bus(0, 12'h008, 0); chk("eot cleared", 0, q[7]);
      bus(1, 12'h018, 32'h0712_005a);
      repeat (120) @(posedge hclk);
      chk("second byte", 8'h5a, got);
      $display("t_master done");
   endtask
   task t_slave;
      int i;
      bus(1, 12'h000, 0); bus(1, 12'h020, 32'h0700_0000); bus(1, 12'h000, 1);
      tb_ssel <= 2'b10;
      repeat (5) @(posedge hclk);
      chk("miso oe", 1, po.miso_oe);
      for (i = 7; i >= 0; i--) begin
         tb_mosi <= i[0] ^ i[1] ^ i[2];
         repeat (4) @(posedge hclk);
         tb_sck <= 1'b1;
         repeat (4) @(posedge hclk);
         tb_sck <= 1'b0;
      end
      repeat (4) @(posedge hclk);
      tb_ssel <= 2'b11;
      repeat (6) @(posedge hclk);
      chk("miso released", 0, po.miso_oe);
      bus(0, 12'h008, 0); chk("slave status", 32'h31, q & 32'h31);
      bus(0, 12'h014, 0); chk("slave rx", 8'h96, q[7:0]);
      $display("t_slave done");
   endtask
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_master;
      t_slave;
      stop_test;
   end
endmodule
